// ===== verilog/adc_level_regs.vh
`ifndef ADC_LEVEL_REGS_VH
`define ADC_LEVEL_REGS_VH
// ==========================================
// control word layout
`define WORD_ADDR_MSB 15
`define WORD_ADDR_LSB 9
`define WORD_DATA_MSB 8
`define WORD_DATA_LSB 0
// ==========================================
// register addresses
`define REG_ZERO_CROSS_TIMEOUT_CTRL 7'h07
`define REG_AUDIO_INTERFACE_CTRL 7'h0b
`define REG_CLOCK_MASTER_CTRL 7'h0c
`define REG_POWER_DOWN_CTRL 7'h0d
`define REG_LEFT_GAIN_CTRL 7'h0e
`define REG_RIGHT_GAIN_CTRL 7'h0f
`define REG_LEVEL_CTRL_FIRST 7'h10
`define REG_LEVEL_CTRL_SECOND 7'h11
`define REG_ATTACK_DECAY_CTRL 7'h12
`define REG_GATE_CTRL 7'h13
`define REG_LIMIT_WINDOW_ATTEN_CTRL 7'h14
`define REG_INPUT_MIX_MUTE_CTRL 7'h15
`define REG_SOFT_REGISTER_RESET 7'h17
// ==========================================
// reset values
`define DEF_ZERO_CROSS_TIMEOUT_CTRL 9'h000
`define DEF_AUDIO_INTERFACE_CTRL 9'h022
`define DEF_CLOCK_MASTER_CTRL 9'h022
`define DEF_POWER_DOWN_CTRL 9'h008
`define DEF_GAIN_CTRL 9'h0cf
`define DEF_LEVEL_CTRL_FIRST 9'h07b
`define DEF_LEVEL_CTRL_SECOND 9'h000
`define DEF_ATTACK_DECAY_CTRL 9'h032
`define DEF_GATE_CTRL 9'h000
`define DEF_LIMIT_WINDOW_ATTEN_CTRL 9'h0a6
`define DEF_INPUT_MIX_MUTE_CTRL 9'h001
`define DEF_UNMAPPED 9'h000
// ==========================================
// field positions
`define LC1_FUNC_MSB 8
`define LC1_FUNC_LSB 7
`define LC1_MAX_GAIN_MSB 6
`define LC1_MAX_GAIN_LSB 4
`define LC1_TARGET_MSB 3
`define LC1_TARGET_LSB 0
`define LC2_ENABLE_BIT 8
`define LC2_ZC_BIT 7
`define LC2_HOLD_MSB 3
`define LC2_HOLD_LSB 0
`define AD_DECAY_MSB 7
`define AD_DECAY_LSB 4
`define AD_ATTACK_MSB 3
`define AD_ATTACK_LSB 0
`define GATE_ENABLE_BIT 0
`define GATE_TH_MSB 4
`define GATE_TH_LSB 2
`define LIM_WINDOW_MSB 6
`define LIM_WINDOW_LSB 4
`define LIM_ATTEN_MSB 3
`define LIM_ATTEN_LSB 0
`define MIX_SEL_MSB 3
`define MIX_SEL_LSB 0
`define PD_INPUT_BUFFER_BIT 6
`define GAIN_MSB 7
`define GAIN_LSB 0
// ==========================================
// function select codes
`define FUNC_LIMITER 2'h0
`define FUNC_RIGHT_BIT 0
`define FUNC_LEFT_BIT 1
// ==========================================
// gain codes, 0.5 dB per step, then attenuation limits in whole dB and max gain field codes
`define GAIN_0DB 8'hcf
`define GAIN_MINUS1DB 8'hcd
`define GAIN_MINUS5DB 8'hc5
`define GAIN_ZERO 8'h00
`define GAIN_ONE_STEP 8'h01
`define ATT_LIM_MIN 4'h3
`define ATT_LIM_MAX 4'hc
`define ATT_ALC_KNEE 4'ha
`define ATT_ALC_BASE 4'hb
`define MAX_GAIN_FLOOR 3'h0
`define MAX_GAIN_ONE 3'h1
// ==========================================
// gate threshold, signed dBFS
`define GATE_TH_BASE_DBFS 8'hb2
// ==========================================
// timing
`define CLK_PERIOD_NS 5
`define HOLD_BASE_NS 2670000
`define HOLD_CODE_ZERO 4'h0
`define HOLD_CODE_ONE 4'h1
`endif

// ===== verilog/gain_limit_decode.v
`timescale 1ns/1ps
`include "adc_level_regs.vh"
module gain_limit_decode (
  input wire limiter_mode_i,
  input wire [2:0] max_gain_limit_i,
  input wire [3:0] max_attenuation_i,
  input wire [7:0] static_gain_i,
  output reg [7:0] upper_gain_o,
  output reg [7:0] lower_gain_o
);

reg [3:0] att_db;
reg [7:0] att_codes;
reg [2:0] gain_steps;
reg [3:0] alc_steps;

always @*
begin
  att_db = max_attenuation_i;
  if (att_db < `ATT_LIM_MIN)
  begin
    att_db = `ATT_LIM_MIN; // RULE_04
  end
  if (att_db > `ATT_LIM_MAX)
  begin
    att_db = `ATT_LIM_MAX; // RULE_04
  end
  att_codes = {3'h0, att_db, 1'b0};
  gain_steps = max_gain_limit_i - `MAX_GAIN_ONE;
  alc_steps = max_attenuation_i - `ATT_ALC_BASE;
  if (limiter_mode_i)
  begin
    upper_gain_o = static_gain_i; // RULE_03
    if (static_gain_i > att_codes)
      lower_gain_o = static_gain_i - att_codes; // RULE_04
    else
      lower_gain_o = `GAIN_ZERO;
  end
  else
  begin
    if (max_gain_limit_i == `MAX_GAIN_FLOOR)
      upper_gain_o = `GAIN_0DB; // RULE_02
    else
      upper_gain_o = `GAIN_0DB + {2'h0, gain_steps, 3'h0}; // RULE_02
    if (max_attenuation_i <= `ATT_ALC_KNEE)
      lower_gain_o = `GAIN_MINUS1DB; // RULE_05
    else
      lower_gain_o = `GAIN_MINUS5DB - {2'h0, alc_steps[2:0], 3'h0}; // RULE_05
  end
end

endmodule

// ===== verilog/adc_level_control.v
// Notes on behaviour
// RULE_01: with level control, zero-cross bit set defers gain updates to zero crossings.
// RULE_02: level control gain ceiling from max_gain_limit, +24dB down in 4dB, 000/001 0dB.
// RULE_03: limiter ignores max_gain_limit entirely.
// RULE_04: limiter floor is static gain minus 3..12dB from max_attenuation.
// RULE_05: level control floor: -1dB up to 1010, -5dB at 1011, 4dB steps to -21dB.
// RULE_06: hold delay before ramp up: 0000 none, 0001 2.67ms, doubling per code.
// RULE_07: hold only delays increases; reduction starts at once when above target.
// RULE_08: above 87.5% full scale, ramp down at fastest attack rate until below.
// RULE_09: overload detection is on whenever level control is enabled.
// RULE_10: input below gate threshold freezes gain, no upward ramp.
// RULE_11: noise gate works only with level control, on the same channels.
// RULE_12: gate_enable bit 0 turns the noise gate on; default off.
// RULE_13: gate_threshold decodes to -78dBFS..-36dBFS in 6dB steps.
// RULE_14: one mixer bit per stereo pair; selected pairs summed; default pair one.
// RULE_15: input_buffer_powerdown ties all mixer inputs to midrail_reference.
// RULE_16: any write to address 0x17 restores every register default.
// RULE_17: host writes zero to unused bits of every control word.
// RULE_18: level_ctrl_enable, second register bit 8, enables gain control; default off.
// RULE_19: function select: limiter, right only, left only, stereo level control.
// RULE_20: limiter uses the louder channel and drives both channels identically.
// RULE_21: control word is 7 address bits over 9 data bits, stored as addressed.
`timescale 1ns/1ps
`include "adc_level_regs.vh"
module adc_level_control #(
  parameter HOLD_BASE_CYCLES = (`HOLD_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter HOLD_CNT_W = 34
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [15:0] ctrl_word_i,
  input wire ctrl_word_valid_i,
  input wire signal_sign_l_i,
  input wire signal_sign_r_i,
  input wire above_target_l_i,
  input wire above_target_r_i,
  input wire overload_l_i,
  input wire overload_r_i,
  input wire below_gate_l_i,
  input wire below_gate_r_i,
  input wire attack_tick_i,
  input wire fast_attack_tick_i,
  input wire decay_tick_i,
  output reg [7:0] pga_gain_l_o,
  output reg [7:0] pga_gain_r_o,
  output reg level_ctrl_active_o,
  output reg limiter_active_o,
  output reg overload_detect_on_o,
  output reg [1:0] gate_active_o,
  output reg [1:0] hold_active_o,
  output reg [7:0] gate_threshold_dbfs_o,
  output reg [3:0] mix_input_enable_o,
  output reg [3:0] midrail_select_o,
  output reg [3:0] attack_time_sel_o,
  output reg [3:0] decay_time_sel_o,
  output reg [3:0] target_level_o,
  output reg [2:0] transient_window_o,
  output reg [8:0] timeout_ctrl_o,
  output reg [8:0] audio_interface_ctrl_o,
  output reg [8:0] clock_master_ctrl_o,
  output reg [8:0] power_down_ctrl_o,
  output reg [8:0] mute_ctrl_o
);

localparam [HOLD_CNT_W-1:0] HOLD_BASE = HOLD_BASE_CYCLES;

// ==========================================
// helpers
function [4:0] reg_index;
  input [6:0] addr;
  begin
    reg_index = addr[4:0];
  end
endfunction

function reg_mapped;
  input [6:0] addr;
  begin
    case (addr)
      `REG_ZERO_CROSS_TIMEOUT_CTRL, `REG_AUDIO_INTERFACE_CTRL,
      `REG_CLOCK_MASTER_CTRL, `REG_POWER_DOWN_CTRL,
      `REG_LEFT_GAIN_CTRL, `REG_RIGHT_GAIN_CTRL,
      `REG_LEVEL_CTRL_FIRST, `REG_LEVEL_CTRL_SECOND,
      `REG_ATTACK_DECAY_CTRL, `REG_GATE_CTRL,
      `REG_LIMIT_WINDOW_ATTEN_CTRL, `REG_INPUT_MIX_MUTE_CTRL:
        reg_mapped = 1'b1;
      default:
        reg_mapped = 1'b0;
    endcase
  end
endfunction

function [8:0] reg_default;
  input [4:0] idx;
  begin
    case ({2'h0, idx})
      `REG_ZERO_CROSS_TIMEOUT_CTRL: reg_default = `DEF_ZERO_CROSS_TIMEOUT_CTRL;
      `REG_AUDIO_INTERFACE_CTRL: reg_default = `DEF_AUDIO_INTERFACE_CTRL;
      `REG_CLOCK_MASTER_CTRL: reg_default = `DEF_CLOCK_MASTER_CTRL;
      `REG_POWER_DOWN_CTRL: reg_default = `DEF_POWER_DOWN_CTRL;
      `REG_LEFT_GAIN_CTRL: reg_default = `DEF_GAIN_CTRL;
      `REG_RIGHT_GAIN_CTRL: reg_default = `DEF_GAIN_CTRL;
      `REG_LEVEL_CTRL_FIRST: reg_default = `DEF_LEVEL_CTRL_FIRST;
      `REG_LEVEL_CTRL_SECOND: reg_default = `DEF_LEVEL_CTRL_SECOND;
      `REG_ATTACK_DECAY_CTRL: reg_default = `DEF_ATTACK_DECAY_CTRL;
      `REG_GATE_CTRL: reg_default = `DEF_GATE_CTRL;
      `REG_LIMIT_WINDOW_ATTEN_CTRL: reg_default = `DEF_LIMIT_WINDOW_ATTEN_CTRL;
      `REG_INPUT_MIX_MUTE_CTRL: reg_default = `DEF_INPUT_MIX_MUTE_CTRL;
      default: reg_default = `DEF_UNMAPPED;
    endcase
  end
endfunction

function [HOLD_CNT_W-1:0] hold_cycles;
  input [3:0] code;
  begin
    if (code == `HOLD_CODE_ZERO)
      hold_cycles = {HOLD_CNT_W{1'b0}};
    else
      hold_cycles = HOLD_BASE << (code - `HOLD_CODE_ONE);
  end
endfunction

// ==========================================
// input synchronisers
reg [7:0] async_meta;
reg [7:0] async_sync;
reg [1:0] sign_prev;

always @(posedge core_clk_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    async_meta <= 8'h00;
    async_sync <= 8'h00;
    sign_prev <= 2'h0;
  end
  else
  begin
    async_meta <= {below_gate_r_i, below_gate_l_i, overload_r_i, overload_l_i,
                   above_target_r_i, above_target_l_i, signal_sign_r_i, signal_sign_l_i};
    async_sync <= async_meta;
    sign_prev <= async_sync[1:0];
  end
end

wire [1:0] zero_cross = async_sync[1:0] ^ sign_prev;
wire [1:0] above_raw = async_sync[3:2];
wire [1:0] overload_raw = async_sync[5:4];
wire [1:0] below_gate_raw = async_sync[7:6];

// ==========================================
// control register file
reg [8:0] ctrl_reg [0:31];
integer i;
wire [6:0] word_addr = ctrl_word_i[`WORD_ADDR_MSB:`WORD_ADDR_LSB];

always @(posedge core_clk_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    for (i = 0; i < 32; i = i + 1)
      ctrl_reg[i] <= reg_default(i[4:0]);
  end
  else if (ctrl_word_valid_i)
  begin
    if (word_addr == `REG_SOFT_REGISTER_RESET)
    begin
      for (i = 0; i < 32; i = i + 1)
        ctrl_reg[i] <= reg_default(i[4:0]); // RULE_16
    end
    else if (reg_mapped(word_addr))
    begin
      // unused bits are stored as sent RULE_17
      ctrl_reg[reg_index(word_addr)] <= ctrl_word_i[`WORD_DATA_MSB:`WORD_DATA_LSB]; // RULE_21
    end
  end
end

wire [8:0] lc_first = ctrl_reg[reg_index(`REG_LEVEL_CTRL_FIRST)];
wire [8:0] lc_second = ctrl_reg[reg_index(`REG_LEVEL_CTRL_SECOND)];
wire [8:0] attack_decay = ctrl_reg[reg_index(`REG_ATTACK_DECAY_CTRL)];
wire [8:0] gate_reg = ctrl_reg[reg_index(`REG_GATE_CTRL)];
wire [8:0] limit_reg = ctrl_reg[reg_index(`REG_LIMIT_WINDOW_ATTEN_CTRL)];
wire [8:0] mix_reg = ctrl_reg[reg_index(`REG_INPUT_MIX_MUTE_CTRL)];
wire [8:0] pd_reg = ctrl_reg[reg_index(`REG_POWER_DOWN_CTRL)];
wire [7:0] static_l = ctrl_reg[reg_index(`REG_LEFT_GAIN_CTRL)][`GAIN_MSB:`GAIN_LSB];
wire [7:0] static_r = ctrl_reg[reg_index(`REG_RIGHT_GAIN_CTRL)][`GAIN_MSB:`GAIN_LSB];

// ==========================================
// mode decode
wire level_ctrl_enable = lc_second[`LC2_ENABLE_BIT]; // RULE_18
wire [1:0] level_function_select = lc_first[`LC1_FUNC_MSB:`LC1_FUNC_LSB];
wire limiter_mode = level_ctrl_enable & (level_function_select == `FUNC_LIMITER); // RULE_19
wire alc_mode = level_ctrl_enable & ~(level_function_select == `FUNC_LIMITER); // RULE_19
wire pga_zc_enable = lc_second[`LC2_ZC_BIT];
wire [3:0] hold_time_sel = lc_second[`LC2_HOLD_MSB:`LC2_HOLD_LSB];
wire gate_enable = gate_reg[`GATE_ENABLE_BIT]; // RULE_12
wire [2:0] gate_threshold = gate_reg[`GATE_TH_MSB:`GATE_TH_LSB];
wire [1:0] ch_ctrl;
assign ch_ctrl[0] = limiter_mode | (alc_mode & level_function_select[`FUNC_LEFT_BIT]); // RULE_19
assign ch_ctrl[1] = limiter_mode | (alc_mode & level_function_select[`FUNC_RIGHT_BIT]); // RULE_19

wire above_both = above_raw[0] | above_raw[1];
wire [1:0] above = limiter_mode ? {above_both, above_both} : above_raw; // RULE_20
wire [1:0] overload = alc_mode ? overload_raw : 2'h0; // RULE_09
wire [1:0] gated = (alc_mode & gate_enable) ? (below_gate_raw & ch_ctrl) : 2'h0; // RULE_11

// ==========================================
// gain limits
wire [7:0] upper_l;
wire [7:0] lower_l;
wire [7:0] upper_r;
wire [7:0] lower_r;

gain_limit_decode limit_left (
  .limiter_mode_i(limiter_mode),
  .max_gain_limit_i(lc_first[`LC1_MAX_GAIN_MSB:`LC1_MAX_GAIN_LSB]),
  .max_attenuation_i(limit_reg[`LIM_ATTEN_MSB:`LIM_ATTEN_LSB]),
  .static_gain_i(static_l),
  .upper_gain_o(upper_l),
  .lower_gain_o(lower_l)
);

gain_limit_decode limit_right (
  .limiter_mode_i(limiter_mode),
  .max_gain_limit_i(lc_first[`LC1_MAX_GAIN_MSB:`LC1_MAX_GAIN_LSB]),
  .max_attenuation_i(limit_reg[`LIM_ATTEN_MSB:`LIM_ATTEN_LSB]),
  .static_gain_i(static_r),
  .upper_gain_o(upper_r),
  .lower_gain_o(lower_r)
);

// ==========================================
// gain tracking
reg [15:0] work_gain;
reg [2*HOLD_CNT_W-1:0] hold_cnt;
reg [15:0] next_work;
reg [2*HOLD_CNT_W-1:0] next_hold;
reg [1:0] next_hold_active;
reg [7:0] g;
reg [7:0] up;
reg [7:0] lo;
reg [HOLD_CNT_W-1:0] h;
wire [HOLD_CNT_W-1:0] hold_target = hold_cycles(hold_time_sel); // RULE_06
integer c;

always @*
begin
  next_work = work_gain;
  next_hold = hold_cnt;
  next_hold_active = 2'h0;
  g = `GAIN_ZERO;
  up = `GAIN_ZERO;
  lo = `GAIN_ZERO;
  h = {HOLD_CNT_W{1'b0}};
  for (c = 0; c < 2; c = c + 1)
  begin
    g = work_gain[c*8 +: 8];
    h = hold_cnt[c*HOLD_CNT_W +: HOLD_CNT_W];
    up = (c == 0) ? upper_l : upper_r;
    lo = (c == 0) ? lower_l : lower_r;
    if (!ch_ctrl[c])
    begin
      g = (c == 0) ? static_l : static_r;
      h = {HOLD_CNT_W{1'b0}};
    end
    else if (overload[c] | above[c])
    begin
      h = {HOLD_CNT_W{1'b0}}; // RULE_07
      if (g > lo && ((overload[c] && fast_attack_tick_i) || (above[c] && attack_tick_i)))
        g = g - `GAIN_ONE_STEP; // RULE_08
    end
    else if (g > up)
      g = up; // RULE_02
    else if (g < lo)
      g = lo; // RULE_05
    else if (gated[c])
      g = g; // RULE_10
    else if (limiter_mode || h >= hold_target)
    begin
      if (decay_tick_i && g < up)
        g = g + `GAIN_ONE_STEP; // RULE_06
    end
    else
    begin
      h = h + {{(HOLD_CNT_W-1){1'b0}}, 1'b1}; // RULE_06
      next_hold_active[c] = 1'b1;
    end
    next_work[c*8 +: 8] = g;
    next_hold[c*HOLD_CNT_W +: HOLD_CNT_W] = h;
  end
  if (limiter_mode)
    next_work[15:8] = next_work[7:0]; // RULE_20
end

wire zc_gating = alc_mode & pga_zc_enable;

always @(posedge core_clk_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    work_gain <= {`GAIN_0DB, `GAIN_0DB};
    hold_cnt <= {2*HOLD_CNT_W{1'b0}};
    pga_gain_l_o <= `GAIN_0DB;
    pga_gain_r_o <= `GAIN_0DB;
    hold_active_o <= 2'h0;
    gate_active_o <= 2'h0;
  end
  else
  begin
    work_gain <= next_work;
    hold_cnt <= next_hold;
    hold_active_o <= next_hold_active;
    gate_active_o <= gated;
    if (!zc_gating || !ch_ctrl[0] || zero_cross[0])
      pga_gain_l_o <= next_work[7:0]; // RULE_01
    if (!zc_gating || !ch_ctrl[1] || zero_cross[1])
      pga_gain_r_o <= next_work[15:8]; // RULE_01
  end
end

// ==========================================
// configuration outputs
wire input_buffer_powerdown = pd_reg[`PD_INPUT_BUFFER_BIT];
wire [3:0] input_mix_select = mix_reg[`MIX_SEL_MSB:`MIX_SEL_LSB];

always @(posedge core_clk_i or negedge reset_n_i)
begin
  if (!reset_n_i)
  begin
    level_ctrl_active_o <= 1'b0;
    limiter_active_o <= 1'b0;
    overload_detect_on_o <= 1'b0;
    gate_threshold_dbfs_o <= `GATE_TH_BASE_DBFS;
    mix_input_enable_o <= 4'h0;
    midrail_select_o <= 4'h0;
    attack_time_sel_o <= 4'h0;
    decay_time_sel_o <= 4'h0;
    target_level_o <= 4'h0;
    transient_window_o <= 3'h0;
    timeout_ctrl_o <= `DEF_ZERO_CROSS_TIMEOUT_CTRL;
    audio_interface_ctrl_o <= `DEF_AUDIO_INTERFACE_CTRL;
    clock_master_ctrl_o <= `DEF_CLOCK_MASTER_CTRL;
    power_down_ctrl_o <= `DEF_POWER_DOWN_CTRL;
    mute_ctrl_o <= `DEF_INPUT_MIX_MUTE_CTRL;
  end
  else
  begin
    level_ctrl_active_o <= alc_mode;
    limiter_active_o <= limiter_mode;
    overload_detect_on_o <= alc_mode; // RULE_09
    gate_threshold_dbfs_o <= `GATE_TH_BASE_DBFS + {3'h0, gate_threshold, 2'h0}
                             + {4'h0, gate_threshold, 1'b0}; // RULE_13
    mix_input_enable_o <= input_buffer_powerdown ? 4'h0 : input_mix_select; // RULE_14
    midrail_select_o <= {4{input_buffer_powerdown}}; // RULE_15
    attack_time_sel_o <= attack_decay[`AD_ATTACK_MSB:`AD_ATTACK_LSB];
    decay_time_sel_o <= attack_decay[`AD_DECAY_MSB:`AD_DECAY_LSB];
    target_level_o <= lc_first[`LC1_TARGET_MSB:`LC1_TARGET_LSB];
    transient_window_o <= limit_reg[`LIM_WINDOW_MSB:`LIM_WINDOW_LSB];
    timeout_ctrl_o <= ctrl_reg[reg_index(`REG_ZERO_CROSS_TIMEOUT_CTRL)];
    audio_interface_ctrl_o <= ctrl_reg[reg_index(`REG_AUDIO_INTERFACE_CTRL)];
    clock_master_ctrl_o <= ctrl_reg[reg_index(`REG_CLOCK_MASTER_CTRL)];
    power_down_ctrl_o <= pd_reg;
    mute_ctrl_o <= mix_reg;
  end
end

endmodule

// ===== testbench/adc_level_control_properties.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module adc_level_control_properties (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [15:0] ctrl_word_i,
  input wire ctrl_word_valid_i,
  input wire [7:0] pga_gain_l_o,
  input wire [7:0] pga_gain_r_o,
  input wire level_ctrl_active_o,
  input wire limiter_active_o,
  input wire overload_detect_on_o,
  input wire [1:0] gate_active_o,
  input wire [1:0] hold_active_o,
  input wire [7:0] gate_threshold_dbfs_o,
  input wire [3:0] mix_input_enable_o,
  input wire [3:0] midrail_select_o,
  input wire [8:0] timeout_ctrl_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // lone write to one address
  sequence s_wr(a);
    ctrl_word_valid_i && ctrl_word_i[15:9] == a ##1 !ctrl_word_valid_i;
  endsequence
  a_mode_exclusive: assert property (!(level_ctrl_active_o && limiter_active_o))
    else $error("both gain modes active");
  a_overload_auto: assert property (overload_detect_on_o == level_ctrl_active_o)
    else $error("overload detect not tied to level control");
  a_gate_needs_lc: assert property (gate_active_o != 2'h0 |->
    level_ctrl_active_o || $past(level_ctrl_active_o))
    else $error("gate active without level control");
  a_limiter_stereo: assert property (limiter_active_o && $past(limiter_active_o, 3) |->
    pga_gain_l_o == pga_gain_r_o)
    else $error("limiter gains differ");
  a_midrail_pd: assert property (midrail_select_o != 4'h0 |->
    midrail_select_o == 4'hf && mix_input_enable_o == 4'h0)
    else $error("midrail select inconsistent");
  a_gate_th_range: assert property (gate_threshold_dbfs_o >= 8'hb2 &&
    gate_threshold_dbfs_o <= 8'hdc && (gate_threshold_dbfs_o - 8'hb2) % 6 == 0)
    else $error("gate threshold off grid");
  a_gate_th_write: assert property (s_wr(7'h13) |-> ##2
    gate_threshold_dbfs_o == 8'hb2 + 8'h06 * {5'h00, $past(ctrl_word_i[4:2], 3)})
    else $error("gate threshold decode wrong");
  a_raw_copy: assert property (s_wr(7'h07) |-> ##2
    timeout_ctrl_o == $past(ctrl_word_i[8:0], 3))
    else $error("register copy wrong");
  a_soft_reset: assert property (s_wr(7'h17) |-> ##2 mix_input_enable_o == 4'h1 &&
    timeout_ctrl_o == 9'h000 && gate_threshold_dbfs_o == 8'hb2 &&
    !level_ctrl_active_o && !limiter_active_o)
    else $error("soft reset left state");
  a_gate_freeze: assert property (gate_active_o[0] && $past(gate_active_o[0]) |->
    pga_gain_l_o <= $past(pga_gain_l_o))
    else $error("gain rose under gate");
  a_hold_no_rise: assert property (hold_active_o[0] && $past(hold_active_o[0]) |->
    pga_gain_l_o <= $past(pga_gain_l_o))
    else $error("gain rose during hold");
endmodule

bind adc_level_control adc_level_control_properties u_props (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ctrl_word_i(ctrl_word_i),
  .ctrl_word_valid_i(ctrl_word_valid_i), .pga_gain_l_o(pga_gain_l_o),
  .pga_gain_r_o(pga_gain_r_o), .level_ctrl_active_o(level_ctrl_active_o),
  .limiter_active_o(limiter_active_o), .overload_detect_on_o(overload_detect_on_o),
  .gate_active_o(gate_active_o), .hold_active_o(hold_active_o),
  .gate_threshold_dbfs_o(gate_threshold_dbfs_o), .mix_input_enable_o(mix_input_enable_o),
  .midrail_select_o(midrail_select_o), .timeout_ctrl_o(timeout_ctrl_o)
);

// ===== testbench/adc_level_control_tb.sv
`timescale 1ns/1ps
module adc_level_control_tb;
  // ==========================================
  // signals
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] word = 16'h0000;
  reg vld = 1'b0;
  reg [1:0] sgn = 2'h0, abv = 2'h0, ovl = 2'h0, blw = 2'h0;
  reg attack_time_sel = 1'b0, fat = 1'b0, dcy = 1'b0;
  wire [7:0] gl, gr, gth;
  wire lca, lim, ovo;
  wire [1:0] gact, hact;
  wire [3:0] mix, mid, ats, dcs, tgt;
  wire [2:0] win;
  wire [8:0] tmo, aif, cmc, pdc, mut;
  integer fails = 0, n_tests = 0, i, k;
  localparam [8:0] DEF [0:14] = '{9'h0b2, 9'h001, 9'h000, 9'h000, 9'h022, 9'h022, 9'h008,
    9'h001, 9'h002, 9'h003, 9'h00b, 9'h002, 9'h000, 9'h0cf, 9'h0cf};
  // address, data, output select, expected
  localparam [28:0] ROWS [0:20] = '{
    {7'h15, 9'h005, 4'h1, 9'h005}, {7'h15, 9'h00f, 4'h1, 9'h00f},
    {7'h15, 9'h00f, 4'h7, 9'h00f}, {7'h0d, 9'h048, 4'h1, 9'h000},
    {7'h0d, 9'h048, 4'h2, 9'h00f}, {7'h0d, 9'h048, 4'h6, 9'h048},
    {7'h0d, 9'h008, 4'h2, 9'h000}, {7'h07, 9'h008, 4'h3, 9'h008},
    {7'h25, 9'h1ff, 4'h3, 9'h008}, {7'h0b, 9'h14a, 4'h4, 9'h14a},
    {7'h0c, 9'h10b, 4'h5, 9'h10b}, {7'h12, 9'h0a5, 4'h8, 9'h005},
    {7'h12, 9'h0a5, 4'h9, 9'h00a}, {7'h10, 9'h07c, 4'ha, 9'h00c},
    {7'h14, 9'h036, 4'hb, 9'h003}, {7'h11, 9'h100, 4'hc, 9'h002},
    {7'h10, 9'h0fb, 4'hc, 9'h005}, {7'h10, 9'h17b, 4'hc, 9'h005},
    {7'h10, 9'h1fb, 4'hc, 9'h005}, {7'h10, 9'h07b, 4'hc, 9'h002},
    {7'h11, 9'h000, 4'hc, 9'h000}};
  adc_level_control #(.HOLD_BASE_CYCLES(16), .HOLD_CNT_W(34)) u_dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .ctrl_word_i(word), .ctrl_word_valid_i(vld),
    .signal_sign_l_i(sgn[0]), .signal_sign_r_i(sgn[1]), .above_target_l_i(abv[0]),
    .above_target_r_i(abv[1]), .overload_l_i(ovl[0]), .overload_r_i(ovl[1]),
    .below_gate_l_i(blw[0]), .below_gate_r_i(blw[1]), .attack_tick_i(attack_time_sel),
    .fast_attack_tick_i(fat), .decay_tick_i(dcy), .pga_gain_l_o(gl), .pga_gain_r_o(gr),
    .level_ctrl_active_o(lca), .limiter_active_o(lim), .overload_detect_on_o(ovo),
    .gate_active_o(gact), .hold_active_o(hact), .gate_threshold_dbfs_o(gth),
    .mix_input_enable_o(mix), .midrail_select_o(mid), .attack_time_sel_o(ats),
    .decay_time_sel_o(dcs), .target_level_o(tgt), .transient_window_o(win),
    .timeout_ctrl_o(tmo), .audio_interface_ctrl_o(aif), .clock_master_ctrl_o(cmc),
    .power_down_ctrl_o(pdc), .mute_ctrl_o(mut)
  );
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task chk(input [8:0] seen, input [8:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task wr(input [6:0] a, input [8:0] d);
  begin
    word = {a, d};
    vld = 1'b1;
    cyc(1);
    vld = 1'b0;
    cyc(2);
  end
  endtask
  task pulse(input integer which, input integer n);
  begin
    repeat (n)
    begin
      attack_time_sel = (which == 0);
      fat = (which == 1);
      dcy = (which == 2);
      cyc(1);
      attack_time_sel = 1'b0;
      fat = 1'b0;
      dcy = 1'b0;
      cyc(1);
    end
  end
  endtask
  function [8:0] obs(input [3:0] s);
    case (s)
      4'h0: obs = {1'b0, gth};
      4'h1: obs = {5'h00, mix};
      4'h2: obs = {5'h00, mid};
      4'h3: obs = tmo;
      4'h4: obs = aif;
      4'h5: obs = cmc;
      4'h6: obs = pdc;
      4'h7: obs = mut;
      4'h8: obs = {5'h00, ats};
      4'h9: obs = {5'h00, dcs};
      4'ha: obs = {5'h00, tgt};
      4'hb: obs = {6'h00, win};
      4'hc: obs = {6'h00, lca, lim, ovo};
      4'hd: obs = {1'b0, gl};
      default: obs = {1'b0, gr};
    endcase
  endfunction
  task chk_defs;
  begin
    for (k = 0; k < 15; k = k + 1)
      chk(obs(k[3:0]), DEF[k]);
  end
  endtask
  task summarize;
  begin
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #50000;
    fails = fails + 1;
    summarize;
  end
  // ==========================================
  // sequence
  initial
  begin
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    chk_defs;
    for (i = 0; i < 21; i = i + 1)
    begin
      wr(ROWS[i][28:22], ROWS[i][21:13]);
      chk(obs(ROWS[i][12:9]), ROWS[i][8:0]);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(7'h13, {4'h0, i[2:0], 2'b01});
      chk({1'b0, gth}, 9'h0b2 + 9'h006 * i[8:0]);
    end
    wr(7'h17, 9'h000);
    chk_defs;
    // stereo level control floors and overload
    wr(7'h11, 9'h100);
    wr(7'h10, 9'h1fb);
    abv = 2'b01;
    cyc(4);
    pulse(0, 4);
    chk({1'b0, gl}, 9'h0cd);
    chk({1'b0, gr}, 9'h0cf);
    wr(7'h14, 9'h0ab);
    abv = 2'b00;
    ovl = 2'b01;
    cyc(4);
    pulse(1, 2);
    chk({1'b0, gl}, 9'h0cb);
    ovl = 2'b00;
    abv = 2'b01;
    cyc(4);
    pulse(0, 12);
    chk({1'b0, gl}, 9'h0c5);
    // noise gate
    abv = 2'b00;
    wr(7'h13, 9'h001);
    blw = 2'b01;
    cyc(4);
    chk({7'h00, gact}, 9'h001);
    pulse(2, 3);
    chk({1'b0, gl}, 9'h0c5);
    wr(7'h13, 9'h000);
    cyc(2);
    chk({7'h00, gact}, 9'h000);
    blw = 2'b00;
    cyc(4);
    pulse(2, 3);
    chk({1'b0, gl}, 9'h0c8);
    // gain ceiling
    wr(7'h10, 9'h19b);
    pulse(2, 10);
    chk({1'b0, gl}, 9'h0cf);
    wr(7'h10, 9'h1ab);
    pulse(2, 10);
    chk({1'b0, gl}, 9'h0d7);
    // hold before ramp up
    wr(7'h10, 9'h1fb);
    wr(7'h11, 9'h101);
    abv = 2'b01;
    cyc(4);
    pulse(0, 1);
    chk({1'b0, gl}, 9'h0d6);
    abv = 2'b00;
    cyc(4);
    chk({8'h00, hact[0]}, 9'h001);
    pulse(2, 1);
    chk({1'b0, gl}, 9'h0d6);
    cyc(20);
    chk({8'h00, hact[0]}, 9'h000);
    pulse(2, 1);
    chk({1'b0, gl}, 9'h0d7);
    // zero-cross gating
    wr(7'h11, 9'h180);
    abv = 2'b01;
    cyc(4);
    pulse(0, 1);
    chk({1'b0, gl}, 9'h0d7);
    sgn = 2'b01;
    cyc(4);
    chk({1'b0, gl}, 9'h0d6);
    // limiter
    abv = 2'b00;
    blw = 2'b01;
    wr(7'h11, 9'h100);
    wr(7'h10, 9'h07b);
    wr(7'h14, 9'h0a3);
    wr(7'h13, 9'h001);
    chk({1'b0, gl}, 9'h0cf);
    chk({7'h00, gact}, 9'h000);
    abv = 2'b10;
    cyc(4);
    pulse(0, 8);
    chk({1'b0, gl}, 9'h0c9);
    chk({1'b0, gr}, 9'h0c9);
    wr(7'h14, 9'h0ac);
    pulse(0, 20);
    chk({1'b0, gl}, 9'h0b7);
    chk({1'b0, gr}, 9'h0b7);
    // reset in mid-run
    rst_n = 1'b0;
    cyc(2);
    chk({1'b0, gl}, 9'h0cf);
    chk({6'h00, lca, lim, ovo}, 9'h000);
    rst_n = 1'b1;
    cyc(2);
    chk_defs;
    summarize;
  end
endmodule
